// ==== shared/gcm_pkg.sv ====
`default_nettype none
package gcm_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int          ADDR_WIDTH      = 12;
    localparam int          DATA_WIDTH      = 32;
    localparam int          FANOUT_DEFAULT  = 10;
    localparam int          COUNT_WIDTH     = 16;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [11:0] CTRL_OFFSET     = 12'h000;
    localparam logic [11:0] STATUS_OFFSET   = 12'h004;
    localparam logic [11:0] EVENT_OFFSET    = 12'h008;
    localparam logic [11:0] COUNT_OFFSET    = 12'h00c;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int          CTRL_SELECT_BIT = 0;
    localparam int          CTRL_ENABLE_BIT = 1;
    localparam int          ST_ACTIVE_BIT   = 0;
    localparam int          ST_SWITCH_BIT   = 1;
    localparam int          ST_BYPASS_BIT   = 2;
    localparam int          ST_DEAD_A_BIT   = 3;
    localparam int          ST_DEAD_B_BIT   = 4;
    localparam int          ST_EN_EFF_BIT   = 5;
    localparam int          ST_INIT_BIT     = 6;
    localparam int          EV_DEAD_A_BIT   = 0;
    localparam int          EV_DEAD_B_BIT   = 1;
    localparam int          EV_SWITCH_BIT   = 2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic        CTRL_SELECT_RST = 1'b1;
    localparam logic        CTRL_ENABLE_RST = 1'b1;
    localparam logic        ACTIVE_SRC_RST  = 1'b1;

    typedef enum logic [1:0] {
        GCM_ST_RUN   = 2'b00,
        GCM_ST_DRAIN = 2'b01,
        GCM_ST_ARM   = 2'b10,
        GCM_ST_RISE  = 2'b11
    } gcm_state_type;

endpackage : gcm_pkg
`default_nettype wire

// ==== shared/gcm_sel_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface gcm_sel_if;
    logic clk_a;
    logic clk_b;
    logic select;
    logic enable;
    logic bypass;
    logic init_n;
    logic out_level;
    logic active_src;
    logic holding;
    logic switching;
    logic en_eff;

    modport ctrl (
        output clk_a, clk_b, select, enable, bypass, init_n,
        input  out_level, active_src, holding, switching, en_eff
    );
    modport core (
        input  clk_a, clk_b, select, enable, bypass, init_n,
        output out_level, active_src, holding, switching, en_eff
    );
endinterface : gcm_sel_if
`default_nettype wire

// ==== hdl/gcm_runt_suppressor.sv ====
`timescale 1ns/10ps
`default_nettype none
module gcm_runt_suppressor (
    input wire logic pclk,
    input wire logic presetn,
    gcm_sel_if.core  sif
);

    gcm_pkg::gcm_state_type state;
    gcm_pkg::gcm_state_type next_state;
    logic                   cur;
    logic                   next_cur;
    logic                   raw;
    logic                   old_clk;
    logic                   new_clk;
    logic                   new_prev;

    assign old_clk = cur ? sif.clk_b : sif.clk_a;
    assign new_clk = sif.select ? sif.clk_b : sif.clk_a;

    // ************************************************************
    // Switchover sequencing
    // ************************************************************
    always_comb begin
        next_state = state;
        next_cur   = cur;
        raw        = 1'b0;
        if (!sif.init_n) begin
            next_state = gcm_pkg::GCM_ST_ARM; // RULE10
            next_cur   = sif.select;
        end else if (sif.bypass) begin
            next_state = gcm_pkg::GCM_ST_RUN; // RULE11
            next_cur   = sif.select;
            raw        = new_clk; // RULE2
        end else begin
            case (state)
                gcm_pkg::GCM_ST_RUN: begin
                    raw = old_clk; // RULE2
                    if (sif.select != cur) begin
                        next_state = gcm_pkg::GCM_ST_DRAIN; // RULE12
                    end
                end
                gcm_pkg::GCM_ST_DRAIN: begin
                    // Old phase runs to its natural end
                    raw = old_clk; // RULE4
                    if (!old_clk) begin
                        next_state = gcm_pkg::GCM_ST_ARM;
                    end
                end
                gcm_pkg::GCM_ST_ARM: begin
                    // Wait for a fall: a low already in progress may be short
                    if (new_prev && !new_clk) begin // RULE4
                        next_state = gcm_pkg::GCM_ST_RISE; // RULE12
                    end
                end
                gcm_pkg::GCM_ST_RISE: begin
                    if (new_clk) begin
                        raw        = 1'b1; // RULE12
                        next_cur   = sif.select;
                        next_state = gcm_pkg::GCM_ST_RUN;
                    end
                end
                default: begin
                    next_state = gcm_pkg::GCM_ST_ARM;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= gcm_pkg::GCM_ST_ARM;
            cur   <= gcm_pkg::ACTIVE_SRC_RST;
        end else begin
            state <= next_state;
            cur   <= next_cur;
        end
    end

    // Resets low so no false fall is seen right after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_prev <= 1'b0;
        end else begin
            new_prev <= new_clk; // RULE4
        end
    end

    // ************************************************************
    // Enable gate and output level
    // ************************************************************
    // Enable only moves in a low phase, so it never cuts a pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sif.en_eff <= 1'b0;
        end else if (!raw) begin
            sif.en_eff <= sif.enable; // RULE8
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sif.out_level <= 1'b0;
        end else begin
            sif.out_level <= raw & sif.en_eff; // RULE6
        end
    end

    assign sif.active_src = cur;
    assign sif.holding    = (state == gcm_pkg::GCM_ST_ARM) && !sif.bypass;
    assign sif.switching  = (state != gcm_pkg::GCM_ST_RUN) && !sif.bypass;

endmodule : gcm_runt_suppressor
`default_nettype wire

// ==== hdl/gcm_fanout_top.sv ====
// Overview of operation
// RULE1 - Same selected clock drives all ten output pairs while enabled.
// RULE2 - Select low follows input A, high input B; complements inverted.
// RULE3 - Source select defaults high, choosing input B.
// RULE4 - Switching sources never shortens a high or low output phase.
// RULE5 - A dead input with no differential swing gives a steady output.
// RULE6 - One enable controls all ten output pairs together.
// RULE7 - Disabled outputs hold true low and complement high.
// RULE8 - Enable changes take effect only during the low output phase.
// RULE9 - Output enable defaults high, outputs enabled.
// RULE10 - Timed power-on reset puts the suppressor in a known state.
// RULE11 - Timing pin strapped high bypasses suppression: plain multiplexer.
// RULE12 - On select change finish phase, hold low, resume on new rising edge.
`timescale 1ns/10ps
`default_nettype none
module gcm_fanout_top #(
    parameter int FANOUT_COUNT = gcm_pkg::FANOUT_DEFAULT
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output var  logic [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    clock_input_a_p,
    input  wire logic                    clock_input_a_n,
    input  wire logic                    clock_input_b_p,
    input  wire logic                    clock_input_b_n,
    input  wire logic                    reset_timing_pin,
    output logic [FANOUT_COUNT-1:0]      fanout_outputs_p,
    output logic [FANOUT_COUNT-1:0]      fanout_outputs_n
);

    gcm_sel_if sif ();

    logic                                ctrl_select;
    logic                                ctrl_enable;
    logic                                strap_taken;
    logic                                bypass;
    logic                                init_done;
    logic [1:0]                          in_p;
    logic [1:0]                          in_n;
    logic [1:0]                          clean;
    logic [1:0]                          dead;
    logic [1:0]                          dead_prev;
    logic [2:0]                          events;
    logic [2:0]                          next_events;
    logic [2:0]                          ev_set;
    logic [2:0]                          ev_clr;
    logic                                src_prev;
    logic                                switch_done;
    logic [gcm_pkg::COUNT_WIDTH-1:0]     switch_count;
    logic                                wr_access;
    logic                                rd_setup;
    logic [31:0]                         read_value;
    logic                                cur_clk;

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic reg_hit(
        input logic [11:0] addr,
        input logic [11:0] offset
    );
        reg_hit = (addr == offset);
    endfunction : reg_hit

    function automatic logic reg_mapped(input logic [11:0] addr);
        reg_mapped = reg_hit(addr, gcm_pkg::CTRL_OFFSET)
                   | reg_hit(addr, gcm_pkg::STATUS_OFFSET)
                   | reg_hit(addr, gcm_pkg::EVENT_OFFSET)
                   | reg_hit(addr, gcm_pkg::COUNT_OFFSET);
    endfunction : reg_mapped

    // ************************************************************
    // APB slave
    // ************************************************************
    // Zero wait states; read data is captured in the setup cycle
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~reg_mapped(paddr);
    assign wr_access = psel & penable & pwrite;
    assign rd_setup  = psel & ~penable & ~pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_select <= gcm_pkg::CTRL_SELECT_RST; // RULE3
            ctrl_enable <= gcm_pkg::CTRL_ENABLE_RST; // RULE9
        end else if (wr_access && reg_hit(paddr, gcm_pkg::CTRL_OFFSET)) begin
            ctrl_select <= pwdata[gcm_pkg::CTRL_SELECT_BIT];
            ctrl_enable <= pwdata[gcm_pkg::CTRL_ENABLE_BIT];
        end
    end

    always_comb begin
        read_value = 32'h0000_0000;
        if (reg_hit(paddr, gcm_pkg::CTRL_OFFSET)) begin
            read_value[gcm_pkg::CTRL_SELECT_BIT] = ctrl_select;
            read_value[gcm_pkg::CTRL_ENABLE_BIT] = ctrl_enable;
        end else if (reg_hit(paddr, gcm_pkg::STATUS_OFFSET)) begin
            read_value[gcm_pkg::ST_ACTIVE_BIT] = sif.active_src;
            read_value[gcm_pkg::ST_SWITCH_BIT] = sif.switching;
            read_value[gcm_pkg::ST_BYPASS_BIT] = bypass;
            read_value[gcm_pkg::ST_DEAD_A_BIT] = dead[0];
            read_value[gcm_pkg::ST_DEAD_B_BIT] = dead[1];
            read_value[gcm_pkg::ST_EN_EFF_BIT] = sif.en_eff;
            read_value[gcm_pkg::ST_INIT_BIT]   = init_done;
        end else if (reg_hit(paddr, gcm_pkg::EVENT_OFFSET)) begin
            read_value[2:0] = events;
        end else if (reg_hit(paddr, gcm_pkg::COUNT_OFFSET)) begin
            read_value[gcm_pkg::COUNT_WIDTH-1:0] = switch_count;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= read_value;
        end
    end

    // ************************************************************
    // Power-on timing and strap capture
    // ************************************************************
    // A pin already high at release means strapped, not charging
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_taken <= 1'b0;
            bypass      <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            bypass      <= reset_timing_pin; // RULE11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_done <= 1'b0;
        end else if (reset_timing_pin) begin
            init_done <= 1'b1; // RULE10
        end
    end

    // ************************************************************
    // Dead input guard
    // ************************************************************
    assign in_p = {clock_input_b_p, clock_input_a_p};
    assign in_n = {clock_input_b_n, clock_input_a_n};

    generate
        for (genvar gi = 0; gi < 2; gi++) begin : g_guard
            logic clean_q;
            logic dead_q;
            // Equal legs stand for a collapsed swing: park low
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    clean_q <= 1'b0;
                    dead_q  <= 1'b0;
                end else begin
                    dead_q  <= (in_p[gi] == in_n[gi]); // RULE5
                    clean_q <= (in_p[gi] != in_n[gi]) & in_p[gi]; // RULE5
                end
            end
            assign clean[gi] = clean_q;
            assign dead[gi]  = dead_q;
        end
    endgenerate

    // ************************************************************
    // Suppressor hookup
    // ************************************************************
    assign sif.clk_a  = clean[0];
    assign sif.clk_b  = clean[1];
    assign sif.select = ctrl_select;
    assign sif.enable = ctrl_enable;
    assign sif.bypass = bypass;
    assign sif.init_n = init_done & strap_taken;

    gcm_runt_suppressor u_runt_suppressor (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif.core)
    );

    // ************************************************************
    // Fanout stage
    // ************************************************************
    generate
        for (genvar gf = 0; gf < FANOUT_COUNT; gf++) begin : g_fan
            logic true_q;
            logic comp_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    true_q <= 1'b0; // RULE7
                    comp_q <= 1'b1; // RULE7
                end else begin
                    true_q <= sif.out_level; // RULE1
                    comp_q <= ~sif.out_level; // RULE2
                end
            end
            assign fanout_outputs_p[gf] = true_q;
            assign fanout_outputs_n[gf] = comp_q;
        end
    endgenerate

    // ************************************************************
    // Event flags and switchover count
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dead_prev <= 2'b00;
            src_prev  <= gcm_pkg::ACTIVE_SRC_RST;
        end else begin
            dead_prev <= dead;
            src_prev  <= sif.active_src;
        end
    end

    assign switch_done = (sif.active_src != src_prev);
    assign ev_set      = {switch_done, dead & ~dead_prev};
    assign ev_clr      = (wr_access && reg_hit(paddr, gcm_pkg::EVENT_OFFSET))
                         ? pwdata[2:0] : 3'h0;

    // New event beats a write-one-to-clear in the same cycle
    always_comb begin
        next_events = (events & ~ev_clr) | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= 3'h0;
        end else begin
            events <= next_events;
        end
    end

    // Count wraps; software takes differences
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_count <= '0;
        end else if (switch_done) begin
            switch_count <= switch_count + 16'h0001;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    assign cur_clk = sif.active_src ? clean[1] : clean[0];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_FANOUT_EQUAL: assert property ( // RULE1
        (fanout_outputs_p == {FANOUT_COUNT{fanout_outputs_p[0]}})
        && (fanout_outputs_n == ~fanout_outputs_p)
    ) else $error("Fanout pairs disagree");

    AST_BYPASS_MUX: assert property ( // RULE11
        sif.bypass && sif.init_n && sif.en_eff
        |=> sif.out_level == $past(ctrl_select ? clean[1] : clean[0])
    ) else $error("Bypass output does not follow the selected input");

    AST_MUX_TO_PIN: assert property ( // RULE2
        sif.bypass && sif.init_n && sif.en_eff && ctrl_select
        |-> ##2 fanout_outputs_p[0] == $past(clean[1], 2)
    ) else $error("Pin does not follow input B two cycles later");

    AST_SELECT_DEFAULT: assert property ( // RULE3
        !strap_taken |-> ctrl_select
    ) else $error("Source select not high after reset");

    AST_NO_SHORT_HIGH: assert property ( // RULE4
        !sif.bypass && $fell(sif.out_level) |-> !$past(cur_clk)
    ) else $error("Output fell while its source was still high");

    AST_DEAD_PARKS_LOW: assert property ( // RULE5
        (clock_input_a_p == clock_input_a_n) [*2]
        |=> !clean[0] && dead[0]
    ) else $error("Dead input A was not parked low");

    AST_DISABLE_ALL: assert property ( // RULE6
        !sif.en_eff [*2] |-> ##2 (fanout_outputs_p == '0)
    ) else $error("Outputs active while disabled");

    AST_DISABLED_LEVELS: assert property ( // RULE7
        !sif.en_eff ##1 !sif.en_eff
        |-> ##2 (fanout_outputs_n == {FANOUT_COUNT{1'b1}})
    ) else $error("Complement outputs not high while disabled");

    AST_ENABLE_LOW_PHASE: assert property ( // RULE8
        $changed(sif.en_eff) |-> !sif.out_level
    ) else $error("Enable changed during a high phase");

    AST_ENABLE_DEFAULT: assert property ( // RULE9
        !strap_taken |-> ctrl_enable
    ) else $error("Output enable not high after reset");

    AST_INIT_HOLDS_LOW: assert property ( // RULE10
        !sif.init_n |=> !sif.out_level
    ) else $error("Output moved before power-on init finished");

    AST_SWITCH_HOLD_LOW: assert property ( // RULE12
        sif.holding |=> !sif.out_level
    ) else $error("Output not held low during switchover");

    COV_SWITCHOVER: cover property (
        sif.switching ##[1:200] !sif.switching && switch_done
    );
    COV_BYPASS: cover property (
        sif.bypass && $rose(sif.out_level)
    );
    COV_DISABLE: cover property (
        $fell(sif.en_eff) ##2 (fanout_outputs_p == '0)
    );
    COV_DEAD_INPUT: cover property (
        $rose(dead[0]) ##1 !sif.out_level
    );

endmodule : gcm_fanout_top
`default_nettype wire

// ==== test/gcm_src_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module gcm_src_model #(
    parameter int HALF_A = 4,
    parameter int HALF_B = 6
) (
    input  wire logic pclk,
    input  wire logic dead_a,
    input  wire logic dead_b,
    output var  logic a_p,
    output var  logic a_n,
    output var  logic b_p,
    output var  logic b_n
);
    int   cnt_a = 0;
    int   cnt_b = 0;
    logic lvl_a = 1'b0;
    logic lvl_b = 1'b0;

    // ****************************************
    // Two free running redundant sources
    // ****************************************
    // Unrelated half periods so a switchover lands mid-phase
    always @(posedge pclk) begin
        cnt_a <= (cnt_a == HALF_A - 1) ? 0 : cnt_a + 1;
        cnt_b <= (cnt_b == HALF_B - 1) ? 0 : cnt_b + 1;
        if (cnt_a == HALF_A - 1) lvl_a <= ~lvl_a;
        if (cnt_b == HALF_B - 1) lvl_b <= ~lvl_b;
    end

    // Stalled source: both legs follow one toggling level, no differential swing
    assign a_p = lvl_a;
    assign a_n = dead_a ? lvl_a : ~lvl_a;
    assign b_p = lvl_b;
    assign b_n = dead_b ? lvl_b : ~lvl_b;
endmodule : gcm_src_model
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
    err_count++; \
    $display("Error at %0t ns: got %h expected %h", $time, got, exp); \
    end end
module tb_top;
    localparam int FAN = 10;
    logic           pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic           penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0]    paddr = 12'h000;
    logic [31:0]    pwdata = 32'h0, prdata, rd_data;
    logic           a_p, a_n, b_p, b_n, rd_err, pin = 1'b0;
    logic           dead_a = 1'b0, dead_b = 1'b0, runt_chk = 1'b0;
    logic [FAN-1:0] q_p, q_n;
    logic [2:0]     hist_a = 3'h0, hist_b = 3'h0;
    logic           last = 1'b0, seen = 1'b0;
    int             len = 0, err_count = 0, checks = 0;

    always #50 pclk = ~pclk;

    gcm_src_model gcm_src_model_i (.pclk(pclk), .dead_a(dead_a),
        .dead_b(dead_b), .a_p(a_p), .a_n(a_n), .b_p(b_p), .b_n(b_n));
    gcm_fanout_top #(.FANOUT_COUNT(FAN)) gcm_fanout_top_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clock_input_a_p(a_p), .clock_input_a_n(a_n),
        .clock_input_b_p(b_p), .clock_input_b_n(b_n),
        .reset_timing_pin(pin), .fanout_outputs_p(q_p),
        .fanout_outputs_n(q_n));

    // ****************************************
    // Input history and phase length monitor
    // ****************************************
    always @(posedge pclk) begin
        hist_a <= {hist_a[1:0], a_p};
        hist_b <= {hist_b[1:0], b_p};
        if (!presetn || !runt_chk) begin
            seen <= 1'b0;
            len  <= 0;
            last <= q_p[0];
        end else if (q_p[0] !== last) begin
            // Shortest legal phase is the faster source's half period
            if (seen && len < 4) begin
                err_count++;
                $display("Error at %0t ns: short output phase", $time);
            end
            seen <= 1'b1;
            len  <= 1;
            last <= q_p[0];
        end else len <= len + 1;
    end

    task automatic conclude();
        $display("Comparisons %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_st(input int b, input logic v);
        int n;
        for (n = 0; n < 300; n++) begin
            apb(1'b0, gcm_pkg::STATUS_OFFSET, 32'h0);
            if (rd_data[b] === v) break;
        end
        `CHK(rd_data[b], v)
    endtask : wait_st

    task automatic follow(input logic src_b, input int n);
        logic e;
        repeat (n) begin
            @(negedge pclk);
            e = src_b ? hist_b[2] : hist_a[2];
            `CHK(q_p, {FAN{e}})
            `CHK(q_n, {FAN{~e}})
        end
    endtask : follow

    task automatic hold_low(input int n);
        repeat (n) begin
            @(negedge pclk);
            `CHK({q_p, q_n}, {{FAN{1'b0}}, {FAN{1'b1}}})
        end
    endtask : hold_low

    task automatic do_reset(input logic strap);
        presetn <= 1'b0;
        pin     <= strap;
        repeat (6) @(posedge pclk);
        `CHK({q_p, q_n}, {{FAN{1'b0}}, {FAN{1'b1}}})
        presetn <= 1'b1;
        runt_chk <= ~strap;
    endtask : do_reset

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        $display("Error at %0t ns: watchdog expired", $time);
        conclude();
    end

    initial begin
        do_reset(1'b0);
        apb(1'b0, gcm_pkg::CTRL_OFFSET, 32'h0);
        `CHK(rd_data, 32'h3)
        repeat (10) @(posedge pclk);
        pin <= 1'b1;
        wait_st(gcm_pkg::ST_INIT_BIT, 1'b1);
        wait_st(gcm_pkg::ST_EN_EFF_BIT, 1'b1);
        wait_st(gcm_pkg::ST_ACTIVE_BIT, 1'b1);
        repeat (20) @(posedge pclk);
        follow(1'b1, 40);
        apb(1'b0, 12'h100, 32'h0);
        `CHK({rd_err, rd_data}, {1'b1, 32'h0})
        apb(1'b1, gcm_pkg::CTRL_OFFSET, 32'h1);
        wait_st(gcm_pkg::ST_EN_EFF_BIT, 1'b0);
        repeat (3) @(posedge pclk);
        hold_low(24);
        apb(1'b1, gcm_pkg::CTRL_OFFSET, 32'h3);
        wait_st(gcm_pkg::ST_EN_EFF_BIT, 1'b1);
        repeat (16) @(posedge pclk);
        follow(1'b1, 24);
        apb(1'b1, gcm_pkg::CTRL_OFFSET, 32'h2);
        wait_st(gcm_pkg::ST_ACTIVE_BIT, 1'b0);
        wait_st(gcm_pkg::ST_SWITCH_BIT, 1'b0);
        repeat (4) @(posedge pclk);
        follow(1'b0, 40);
        apb(1'b0, gcm_pkg::COUNT_OFFSET, 32'h0);
        `CHK(rd_data, 32'h1)
        apb(1'b0, gcm_pkg::EVENT_OFFSET, 32'h0);
        `CHK(rd_data[gcm_pkg::EV_SWITCH_BIT], 1'b1)
        apb(1'b1, gcm_pkg::EVENT_OFFSET, 32'h4);
        apb(1'b0, gcm_pkg::EVENT_OFFSET, 32'h0);
        `CHK(rd_data[gcm_pkg::EV_SWITCH_BIT], 1'b0)
        // Stall source A in its low phase so no high phase is cut
        @(negedge a_p);
        dead_a <= 1'b1;
        repeat (8) @(posedge pclk);
        hold_low(30);
        wait_st(gcm_pkg::ST_DEAD_A_BIT, 1'b1);
        apb(1'b0, gcm_pkg::EVENT_OFFSET, 32'h0);
        `CHK(rd_data[gcm_pkg::EV_DEAD_A_BIT], 1'b1)
        apb(1'b1, gcm_pkg::CTRL_OFFSET, 32'h3);
        wait_st(gcm_pkg::ST_ACTIVE_BIT, 1'b1);
        wait_st(gcm_pkg::ST_SWITCH_BIT, 1'b0);
        // A returns mid-phase; only safe once B is in use
        dead_a <= 1'b0;
        repeat (4) @(posedge pclk);
        follow(1'b1, 30);
        do_reset(1'b1);
        wait_st(gcm_pkg::ST_BYPASS_BIT, 1'b1);
        wait_st(gcm_pkg::ST_EN_EFF_BIT, 1'b1);
        repeat (16) @(posedge pclk);
        follow(1'b1, 20);
        apb(1'b1, gcm_pkg::CTRL_OFFSET, 32'h2);
        repeat (4) @(posedge pclk);
        follow(1'b0, 20);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
